// *** bench/test_rlom_top.sv ***
/*
  Self-checking bench for the right line-output mixer control bank.
  Assumes the core folder is on the include path and drives every
  input on the falling edge of core_clk.
*/
`timescale 1ns/1ps
`include "rlom_regs.svh"
module test_rlom_top;
  logic                      core_clk, rst_n, reg_wr, reg_rd;
  logic                      gain_settled, drv_powered;
  logic [7:0]                reg_addr, reg_wdata, reg_rdata, rd_q;
  logic                      reg_rvalid, out_unmute;
  logic [5:0]                route_en;
  rlom_pkg::rlom_atten_arr_t atten_code;
  rlom_pkg::rlom_level_t     out_level;
  int                        fails, num_checks;

  rlom_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .gain_settled(gain_settled), .drv_powered(drv_powered),
    .route_en(route_en), .atten_code(atten_code), .out_level(out_level),
    .out_unmute(out_unmute));

  // ----------------------------------------------------------------
  // Clock, compare and bus tasks
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe, released at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr

  // Bounded wait on the valid pulse so a late answer is reported, not hung on
  task automatic rd(input logic [7:0] a);
    int n;
    reg_rd = 1'b1; reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge core_clk);
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    rd_q = reg_rdata;
    // Let an edge pass so a following read never retoggles the strobe at once
    @(negedge core_clk);
  endtask : rd

  task automatic end_sim;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(`RLOM_ADDR_SRC_FIRST + 8'(i));
      chk("src reset", 8'h00, rd_q);
      chk("atten reset", 8'h00, {1'b0, atten_code[i]});
    end
    rd(`RLOM_ADDR_LEVEL_CTRL);
    chk("level reset", 8'h02, rd_q);
    chk("route reset", 8'h00, {2'b00, route_en});
    chk("level pins reset", 8'h00, {3'h0, out_level, out_unmute});
  endtask : t_reset

  // Distinct bytes per source catch swapped indices
  task automatic t_sources;
    for (int i = 0; i < 6; i++) wr(`RLOM_ADDR_SRC_FIRST + 8'(i), 8'h80 | 8'(i * 17 + 3));
    chk("route all", 8'h3f, {2'b00, route_en});
    for (int i = 0; i < 6; i++) begin
      rd(`RLOM_ADDR_SRC_FIRST + 8'(i));
      chk("src read", 8'h80 | 8'(i * 17 + 3), rd_q);
      chk("atten pin", 8'(i * 17 + 3), {1'b0, atten_code[i]});
      wr(`RLOM_ADDR_SRC_FIRST + 8'(i), 8'h7f);
      chk("route off", 8'h00, {7'h00, route_en[i]});
      chk("atten max", 8'h7f, {1'b0, atten_code[i]});
    end
  endtask : t_sources

  // Only codes 0..9 are ever written; status bits written as ones must not
  // stick, and the reserved bit is always written as zero
  task automatic t_level;
    for (int c = 0; c <= 9; c++) begin
      wr(`RLOM_ADDR_LEVEL_CTRL, {4'(c), 4'hb});
      chk("out_level", 8'(c), {4'h0, out_level});
      chk("unmute", 8'h01, {7'h00, out_unmute});
      rd(`RLOM_ADDR_LEVEL_CTRL);
      chk("level read", {4'(c), 4'b1010}, rd_q);
    end
    wr(`RLOM_ADDR_LEVEL_CTRL, 8'h50);
    chk("mute", 8'h00, {7'h00, out_unmute});
    chk("level kept", 8'h05, {4'h0, out_level});
  endtask : t_level

  // Status follows the pins only, whatever is written over it
  task automatic t_status;
    gain_settled = 1'b1; drv_powered = 1'b1;
    repeat (3) @(negedge core_clk);
    wr(`RLOM_ADDR_LEVEL_CTRL, 8'h93);
    rd(`RLOM_ADDR_LEVEL_CTRL);
    chk("status on", 8'h91, rd_q);
    gain_settled = 1'b0;
    repeat (3) @(negedge core_clk);
    wr(`RLOM_ADDR_LEVEL_CTRL, 8'h90);
    rd(`RLOM_ADDR_LEVEL_CTRL);
    chk("gain pending", 8'h93, rd_q);
    drv_powered = 1'b0;
    repeat (3) @(negedge core_clk);
    rd(`RLOM_ADDR_LEVEL_CTRL);
    chk("power off", 8'h92, rd_q);
  endtask : t_status

  // Neighbours of the map must not alias onto any register
  task automatic t_unmapped;
    wr(8'h5e, 8'hff);
    wr(8'h56, 8'hff);
    chk("route hold", 8'h00, {2'b00, route_en});
    chk("level hold", 8'h09, {4'h0, out_level});
    rd(8'h5e);
    chk("unmapped read", 8'h00, rd_q);
  endtask : t_unmapped

  // Reset in mid-run returns every control and status bit to its reset value
  task automatic t_rerst;
    wr(`RLOM_ADDR_RDAC_MIX, 8'hff);
    wr(`RLOM_ADDR_LEVEL_CTRL, 8'h9b);
    chk("route set", 8'h20, {2'b00, route_en});
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    chk("route rerst", 8'h00, {2'b00, route_en});
    chk("atten rerst", 8'h00, {1'b0, atten_code[5]});
    chk("level rerst", 8'h00, {3'h0, out_level, out_unmute});
    rd(`RLOM_ADDR_LEVEL_CTRL);
    chk("status rerst", 8'h02, rd_q);
  endtask : t_rerst

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fails = 0; num_checks = 0;
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    gain_settled = 1'b0; drv_powered = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_sources();
    t_level();
    t_status();
    t_unmapped();
    t_rerst();
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100us;
    fails++;
    end_sim();
  end
endmodule : test_rlom_top

// *** core/rlom_bank_if.sv ***
/*
  Carrier between the control bank top and its source register bank.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface rlom_bank_if;
  logic                      wr_en;    // One-cycle write strobe
  rlom_pkg::rlom_idx_t       wr_idx;   // Source index 0..5
  logic [7:0]                wr_data;  // Byte to store
  logic [5:0]                route;    // Routing enables
  rlom_pkg::rlom_atten_arr_t atten;    // Attenuation codes

  modport ctrl (output wr_en, output wr_idx, output wr_data, input route, input atten);
  modport bank (input wr_en, input wr_idx, input wr_data, output route, output atten);
endinterface : rlom_bank_if

// *** core/rlom_pkg.sv ***
/*
  Types shared by the right line-output mixer control bank.
  Assumes nothing of its surroundings.
*/
package rlom_pkg;
  typedef logic [6:0]      rlom_atten_t;
  typedef logic [5:0][6:0] rlom_atten_arr_t;
  typedef logic [3:0]      rlom_level_t;
  typedef logic [2:0]      rlom_idx_t;
endpackage : rlom_pkg

// *** core/rlom_regs.svh ***
/*
  Register map constants for the right line-output mixer control bank.
  Assumes it is included by its bare name from the core folder.
*/
`ifndef RLOM_REGS_SVH
`define RLOM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RLOM_ADDR_SECOND_LINE_INPUT_LEFT_MIX  8'h57
`define RLOM_ADDR_LAMP_MIX    8'h58
`define RLOM_ADDR_LDAC_MIX    8'h59
`define RLOM_ADDR_SECOND_LINE_INPUT_RIGHT_MIX  8'h5a
`define RLOM_ADDR_RAMP_MIX    8'h5b
`define RLOM_ADDR_RDAC_MIX    8'h5c
`define RLOM_ADDR_LEVEL_CTRL  8'h5d
`define RLOM_ADDR_SRC_FIRST   8'h57
`define RLOM_ADDR_SRC_LAST    8'h5c
`define RLOM_NUM_SRC          6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RLOM_SRC_ROUTE_BIT    7
`define RLOM_SRC_ATTEN_MSB    6
`define RLOM_SRC_ATTEN_LSB    0
`define RLOM_LVL_MSB          7
`define RLOM_LVL_LSB          4
`define RLOM_MUTE_BIT         3
`define RLOM_RSVD_BIT         2
`define RLOM_GAIN_BUSY_BIT    1
`define RLOM_PWR_BIT          0

// ----------------------------------------------------------------
// Reset values and decoded codes
// ----------------------------------------------------------------
`define RLOM_RST_ROUTE        1'b0
`define RLOM_RST_ATTEN        7'h00
`define RLOM_RST_LEVEL        4'h0
`define RLOM_RST_UNMUTE       1'b0
`define RLOM_RST_GAIN_BUSY    1'b1
`define RLOM_RST_PWR          1'b0
`define RLOM_RSVD_VAL         1'b0
`define RLOM_LEVEL_MAX        4'h9
`define RLOM_IDX_W            3
`define RLOM_RST_RDATA        8'h00
`define RLOM_UNMAPPED_VAL     8'h00

`endif

// *** core/rlom_src_bank.sv ***
/*
  Six source-path registers: routing enable and attenuation code each.
  Assumes writes arrive already decoded to an index in range.
*/
`timescale 1ns/1ps
`include "rlom_regs.svh"
module rlom_src_bank (
  input  wire logic  core_clk,  // System clock
  input  wire logic  rst_n,     // Async reset, active low
  rlom_bank_if.bank  bus        // Write side and register view
);
  // ----------------------------------------------------------------
  // Source registers
  // ----------------------------------------------------------------
  logic [5:0]                route_q;
  rlom_pkg::rlom_atten_arr_t atten_q;

  // Store D7 as routing enable and D6-D0 as code, per index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= {`RLOM_NUM_SRC{`RLOM_RST_ROUTE}};                           // R1
      atten_q <= {`RLOM_NUM_SRC{`RLOM_RST_ATTEN}};                           // R2
    end else if (bus.wr_en) begin
      route_q[bus.wr_idx] <= bus.wr_data[`RLOM_SRC_ROUTE_BIT];               // R1
      atten_q[bus.wr_idx] <= bus.wr_data[`RLOM_SRC_ATTEN_MSB:`RLOM_SRC_ATTEN_LSB]; // R2
    end
  end

  assign bus.route = route_q;
  assign bus.atten = atten_q;
endmodule : rlom_src_bank

// *** core/rlom_top.sv ***
/*
  Control register bank for the right line-output mixer: six source
  paths and the output stage register, on a simple byte register port.
  Assumes the register port runs on core_clk, and that the analog
  status inputs come from outside this clock domain.
*/
`timescale 1ns/1ps
`include "rlom_regs.svh"
// Summary of operation
// R1 - Each source register bit 7 routes its source; read/write, resets to zero.
// R2 - Each source register bits 6-0 hold attenuation code, reset zero, exported.
// R3 - Output stage bits 7-4 hold output level 0..9 dB, reset zero.
// R4 - Software never writes level codes ten through fifteen.
// R5 - Output stage bit 3 is mute control; zero mutes, one unmutes.
// R6 - Output stage bit 2 reads zero; software leaves it alone.
// R7 - Bit 1 reads one until all programmed gains are applied; resets one.
// R8 - Bit 0 reads one only when the output driver is fully powered.
// R9 - Writes never change bits 2..0; bits 1..0 follow internal status only, bit 2 is hard zero.
module rlom_top (
  input  wire logic                      core_clk,      // 100 MHz system clock
  input  wire logic                      rst_n,         // Async reset, active low
  input  wire logic                      reg_wr,        // Register write strobe
  input  wire logic                      reg_rd,        // Register read strobe
  input  wire logic [7:0]                reg_addr,      // Register offset
  input  wire logic [7:0]                reg_wdata,     // Write data
  output logic [7:0]                     reg_rdata,     // Read data, one cycle later
  output logic                           reg_rvalid,    // Read data valid pulse
  input  wire logic                      gain_settled,  // Analog: gains applied
  input  wire logic                      drv_powered,   // Analog: driver powered
  output logic [5:0]                     route_en,      // Source routing enables
  output rlom_pkg::rlom_atten_arr_t      atten_code,    // Source attenuation codes
  output rlom_pkg::rlom_level_t          out_level,     // Output level code
  output logic                           out_unmute     // 1 unmutes the output
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  rlom_bank_if bank_bus ();

  // Offset to source index; only meaningful when the offset is a source
  function automatic rlom_pkg::rlom_idx_t src_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff      = addr - `RLOM_ADDR_SRC_FIRST;
    src_index = diff[`RLOM_IDX_W-1:0];
  endfunction : src_index

  function automatic logic is_src(input logic [7:0] addr);
    is_src = (addr >= `RLOM_ADDR_SRC_FIRST) && (addr <= `RLOM_ADDR_SRC_LAST);
  endfunction : is_src

  // Named decode wires
  wire       wr_src   = reg_wr && is_src(reg_addr);
  wire       wr_lvl   = reg_wr && (reg_addr == `RLOM_ADDR_LEVEL_CTRL);
  wire       rd_src   = is_src(reg_addr);
  wire       rd_lvl   = (reg_addr == `RLOM_ADDR_LEVEL_CTRL);
  wire [2:0] addr_idx = src_index(reg_addr);

  assign bank_bus.wr_en   = wr_src;
  assign bank_bus.wr_idx  = addr_idx;
  assign bank_bus.wr_data = reg_wdata;

  // ----------------------------------------------------------------
  // Source register bank
  // ----------------------------------------------------------------
  rlom_src_bank u_src_bank (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (bank_bus.bank)
  );

  assign route_en   = bank_bus.route;
  assign atten_code = bank_bus.atten;

  // ----------------------------------------------------------------
  // Output stage control fields
  // ----------------------------------------------------------------
  rlom_pkg::rlom_level_t level_q;
  logic                  unmute_q;

  // Only D7-D3 are writable; low bits of the byte are dropped here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q  <= `RLOM_RST_LEVEL;                                  // R3
      unmute_q <= `RLOM_RST_UNMUTE;                                 // R5
    end else if (wr_lvl) begin
      level_q  <= reg_wdata[`RLOM_LVL_MSB:`RLOM_LVL_LSB];           // R3
      unmute_q <= reg_wdata[`RLOM_MUTE_BIT];                        // R5
    end
  end

  assign out_level  = level_q;
  assign out_unmute = unmute_q;

  // ----------------------------------------------------------------
  // Status synchronisers
  // ----------------------------------------------------------------
  logic settled_s1_q;
  logic settled_s2_q;
  logic powered_s1_q;
  logic powered_s2_q;

  // Two flops each; status pins come from the analog domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settled_s1_q <= ~`RLOM_RST_GAIN_BUSY;
      settled_s2_q <= ~`RLOM_RST_GAIN_BUSY;
      powered_s1_q <= `RLOM_RST_PWR;
      powered_s2_q <= `RLOM_RST_PWR;
    end else begin
      settled_s1_q <= gain_settled;
      settled_s2_q <= settled_s1_q;
      powered_s1_q <= drv_powered;
      powered_s2_q <= powered_s1_q;
    end
  end

  // Status bits are driven by the analog side only, never by writes
  wire gain_busy = ~settled_s2_q;                                   // R7 R9
  wire pwr_up    = powered_s2_q;                                    // R8 R9

  // Full view of the output stage byte; reserved bit hard zero
  wire [7:0] lvl_view = {level_q, unmute_q, `RLOM_RSVD_VAL, gain_busy, pwr_up}; // R6 R9

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Source view picks the addressed bank entry; only used for source offsets
  wire [7:0] src_view = {route_en[addr_idx], atten_code[addr_idx]}; // R1 R2
  wire [7:0] rd_mux   = rd_src ? src_view : (rd_lvl ? lvl_view : `RLOM_UNMAPPED_VAL);

  // Registered answer; unmapped offsets read as zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= `RLOM_RST_RDATA;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Write to a source register lands one cycle later
  sequence src_write_s;
    reg_wr && is_src(reg_addr);
  endsequence

  // Index and byte are taken from the cycle of the strobe
  route_write_a: assert property (src_write_s |=> // R1
      route_en[$past(addr_idx)] == $past(reg_wdata[`RLOM_SRC_ROUTE_BIT]))
    else $error("routing enable did not take the written bit");

  // Same decode for the code field; the hold check covers only cycles without a write
  atten_write_a: assert property (src_write_s |=> // R2
      atten_code[$past(addr_idx)] == $past(reg_wdata[`RLOM_SRC_ATTEN_MSB:`RLOM_SRC_ATTEN_LSB]))
    else $error("attenuation code did not take the written value");

  // Without a write, source registers and output controls hold
  hold_idle_a: assert property (!reg_wr |=> // R1 R2 R3 R5
      $stable(route_en) && $stable(atten_code) && $stable(out_level) && $stable(out_unmute))
    else $error("control changed without a write");

  // Output stage fields follow the byte written to the level register
  level_write_a: assert property (wr_lvl |=> // R3
      out_level == $past(reg_wdata[`RLOM_LVL_MSB:`RLOM_LVL_LSB]))
    else $error("output level did not take the written code");

  // Mute bit is active low on the output: one means sound passes
  mute_write_a: assert property (wr_lvl |=> // R5
      out_unmute == $past(reg_wdata[`RLOM_MUTE_BIT]))
    else $error("mute control did not take the written bit");

  // Busy flag follows the settled pin after two flops, whatever is written
  sequence settled_steady_s;
    $stable(gain_settled) [*3];
  endsequence

  gain_status_a: assert property (settled_steady_s ##0 (reg_rd && rd_lvl) |=> // R7
      reg_rdata[`RLOM_GAIN_BUSY_BIT] == !$past(gain_settled))
    else $error("gain status does not follow the settled input");

  // Pin edges reach the power bit exactly two cycles late, never earlier
  sequence pwr_rise_s;
    $rose(drv_powered) ##1 drv_powered;
  endsequence

  sequence pwr_fall_s;
    $fell(drv_powered) ##1 !drv_powered;
  endsequence

  power_status_a: assert property (pwr_rise_s |-> !pwr_up ##1 pwr_up) // R8
    else $error("power status did not rise two cycles after the pin");

  power_drop_a: assert property (pwr_fall_s |-> pwr_up ##1 !pwr_up) // R8
    else $error("power status did not fall two cycles after the pin");

  // Reserved bit reads zero and the power bit shows the synchronised pin
  status_ro_a: assert property ((reg_rd && rd_lvl) |=> // R9
      reg_rdata[`RLOM_RSVD_BIT] == `RLOM_RSVD_VAL
      && reg_rdata[`RLOM_PWR_BIT] == $past(powered_s2_q))
    else $error("read-only status bits affected by software");

  // Unmapped offsets answer zero
  unmapped_read_a: assert property ((reg_rd && !rd_src && !rd_lvl) |=>
      reg_rdata == `RLOM_UNMAPPED_VAL)
    else $error("unmapped offset did not read zero");

  // Valid pulse stands for exactly the cycle after the strobe
  read_valid_a: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read valid pulse mistimed");

  // No strobe, no pulse
  rvalid_idle_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid pulse without a read");
endmodule : rlom_top
